// ---- rtl/ast_defines.vh ----
// constants for the aal statistics counter and threshold engine
// assumes a 200 MHz core clock and an external 32-bit statistics ram
`ifndef AST_DEFINES_VH
`define AST_DEFINES_VH
`define AST_OFF_CTRL      12'h000
`define AST_OFF_STATUS    12'h004
`define AST_OFF_QUEUE     12'h008
`define AST_OFF_LAST      12'h00c
`define AST_OFF_DROPPED   12'h010
`define AST_CTRL_RUN      0
`define AST_CTRL_RESTART  1
`define AST_CTRL_SDTONCE  2
`define AST_CTRL_AALEN    31:16
`define AST_CTRL_RESET    32'h0000_0001
`define AST_SAT_VALUE     31'h4000_0000
`define AST_FLAG_BIT      31
`define AST_VAL_MSB       30
`define AST_CNT_BASE      18'h20000
`define AST_THR_BASE      18'h22000
`define AST_SHARED_PORT   3'h7
`define AST_SHARED_CHAN   5'h1f
`define AST_UNSTR_CHAN    5'h00
`define AST_PTR_LOW       7'd93
`define AST_PTR_HIGH      7'd127
`define AST_CNT_OVR       4'h4
`define AST_CNT_OVREND    4'h5
`define AST_CNT_HDR       4'h6
`define AST_CNT_SCTRANS   4'h7
`define AST_CNT_MISINS    4'h8
`define AST_CNT_SCDISC    4'h9
`define AST_CNT_PTRREJ    4'ha
`define AST_CNT_MULTIPTR  4'hb
`define AST_CNT_UFSTART   4'hc
`define AST_CNT_STARVE    4'hd
`define AST_CNT_REFRAME   4'he
`define AST_CNT_LOST      4'hf
`define AST_CNT_SHARED    4'h0
`define AST_QUEUE_NE_BIT  15
`endif

// ---- rtl/ast_counter_engine.v ----
// aal statistics counter engine with threshold queue entries
// assumes an external ram with one cycle read latency and apb software access
//
// Chosen here: the APB interface to the registers.
`include "ast_defines.vh"

module ast_counter_engine (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        ev_valid,
  output wire        ev_ready,
  input  wire [2:0]  ev_port,
  input  wire [4:0]  ev_chan,
  input  wire        ev_active,
  input  wire        ev_unstructured,
  input  wire        ev_aal1,
  input  wire        ev_ovr_cross,
  input  wire        ev_ovr_discard,
  input  wire        ev_ovr_end,
  input  wire        ev_hdr_crc_fixed,
  input  wire        ev_hdr_crc_bad,
  input  wire        ev_hdr_parity,
  input  wire        ev_sc_sync_oos,
  input  wire        ev_sc_inv_oosync,
  input  wire        ev_misinsert,
  input  wire        ev_sc_discard,
  input  wire        ev_lost,
  input  wire        ev_ptr_parity,
  input  wire [6:0]  ev_ptr_value,
  input  wire        ev_ptr_seen,
  input  wire        ev_multi_ptr,
  input  wire        ev_uf_start,
  input  wire        ev_starve,
  input  wire        ev_reframe,
  input  wire        ev_shared_drop,
  output reg         buf_restart,
  output reg         starve_insert,
  output reg         ram_req,
  output reg         ram_we,
  output reg  [17:0] ram_addr,
  output reg  [31:0] ram_wdata,
  input  wire [31:0] ram_rdata,
  output reg         queue_push,
  output reg  [15:0] queue_entry
);

  localparam ST_IDLE  = 3'd0;
  localparam ST_RDCNT = 3'd1;
  localparam ST_RDTHR = 3'd2;
  localparam ST_WAIT  = 3'd3;
  localparam ST_WRITE = 3'd4;

  reg  [31:0] ctrl;
  reg  [15:0] pend;
  reg  [2:0]  cur_port;
  reg  [4:0]  cur_chan;
  reg  [3:0]  cur_idx;
  reg  [2:0]  state;
  reg  [31:0] cnt_word;
  reg  [15:0] queue_count;
  reg  [15:0] last_entry;
  reg  [15:0] dropped;
  reg  [15:0] ev_vec;
  reg  [3:0]  pick;
  reg         pick_ok;
  reg  [30:0] next_val;
  reg         next_flag;
  reg         hit;
  reg  [4:0]  use_chan;
  reg  [2:0]  use_port;
  reg  [2:0]  srv_port;
  reg  [4:0]  srv_chan;
  wire        allowed;
  wire        restart_on;
  wire        sdt_once;
  wire [15:0] aal_en;
  wire        ptr_gap;
  wire        ptr_bad;
  wire        apb_wr;
  wire        apb_rd;
  wire        starve_req;
  wire        ev_take;
  wire        ev_drop;
  wire        thr_act;
  wire [30:0] thr_val;
  wire        thr_usable;
  wire        thr_reached;
  wire        flag_free;
  wire [17:0] srv_cnt_addr;
  wire [17:0] srv_thr_addr;
  wire [15:0] srv_entry;
  integer     i;

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign apb_wr = psel & penable & pwrite;
  // read data is latched in the setup cycle
  assign apb_rd = psel & ~penable & ~pwrite;

  // engine only accepts a new event set once the pending set is drained
  assign ev_ready = ctrl[`AST_CTRL_RUN] & (pend == 16'h0000);
  assign restart_on = ctrl[`AST_CTRL_RESTART];
  assign sdt_once = ctrl[`AST_CTRL_SDTONCE];
  assign aal_en = ctrl[`AST_CTRL_AALEN];
  assign allowed = ev_active;
  assign ev_take = ev_valid & ev_ready & allowed & (ev_vec != 16'h0000);
  assign ev_drop = ev_valid & ~ev_ready & allowed & (ev_vec != 16'h0000);

  // pointer values strictly between the two limits are rejected
  assign ptr_gap = (ev_ptr_value > `AST_PTR_LOW) & (ev_ptr_value < `AST_PTR_HIGH);
  assign ptr_bad = ev_ptr_seen & (ev_ptr_parity | ptr_gap);
  assign starve_req = ev_starve & ~restart_on;

  // threshold word fields, on ram_rdata in the wait state
  assign thr_act = ram_rdata[`AST_FLAG_BIT];
  assign thr_val = ram_rdata[`AST_VAL_MSB:0];
  // a threshold beyond saturation can never be reached
  assign thr_usable = thr_act & (thr_val <= `AST_SAT_VALUE);
  assign thr_reached = (next_val >= thr_val);
  // stored flag blocks a second push
  assign flag_free = ~cnt_word[`AST_FLAG_BIT];

  // addresses and entry of the counter being served
  assign srv_cnt_addr = `AST_CNT_BASE | {5'h00, srv_port, srv_chan, cur_idx, 1'b0};
  assign srv_thr_addr = `AST_THR_BASE | {5'h00, srv_port, srv_chan, cur_idx, 1'b0};
  assign srv_entry = {1'b1, 3'h0, srv_port, srv_chan, cur_idx};

  always @*
  begin
    ev_vec = 16'h0000;
    ev_vec[`AST_CNT_SHARED]   = ev_shared_drop;
    ev_vec[`AST_CNT_OVR]      = ev_ovr_cross | ev_ovr_discard;
    ev_vec[`AST_CNT_OVREND]   = ev_ovr_end;
    ev_vec[`AST_CNT_HDR]      = ev_aal1 & (ev_hdr_crc_fixed | ev_hdr_crc_bad | ev_hdr_parity);
    ev_vec[`AST_CNT_SCTRANS]  = ev_aal1 & (ev_sc_sync_oos | ev_sc_inv_oosync);
    ev_vec[`AST_CNT_MISINS]   = ev_aal1 & ev_misinsert;
    ev_vec[`AST_CNT_SCDISC]   = ev_aal1 & ev_sc_discard;
    ev_vec[`AST_CNT_LOST]     = ev_aal1 & ev_lost;
    ev_vec[`AST_CNT_PTRREJ]   = ev_aal1 & ptr_bad;
    ev_vec[`AST_CNT_MULTIPTR] = ev_aal1 & ev_multi_ptr & sdt_once;
    ev_vec[`AST_CNT_UFSTART]  = ev_uf_start;
    ev_vec[`AST_CNT_STARVE]   = starve_req;
    ev_vec[`AST_CNT_REFRAME]  = ev_aal1 & ~ev_unstructured & ev_reframe;
    ev_vec = ev_vec & aal_en;
  end

  // lowest pending counter is served first
  always @*
  begin
    pick = 4'h0;
    pick_ok = 1'b0;
    for (i = 15; i >= 0; i = i - 1)
    begin
      if (pend[i])
      begin
        pick = i[3:0];
        pick_ok = 1'b1;
      end
    end
  end

  always @*
  begin
    use_port = cur_port;
    use_chan = cur_chan;
    if (pick == `AST_CNT_SHARED)
    begin
      use_port = `AST_SHARED_PORT;
      use_chan = `AST_SHARED_CHAN;
    end
  end

  // saturating add and threshold test on the freshly read words
  always @*
  begin
    next_val = cnt_word[`AST_VAL_MSB:0];
    if (cnt_word[`AST_VAL_MSB:0] < `AST_SAT_VALUE)
      next_val = cnt_word[`AST_VAL_MSB:0] + 31'h0000_0001;
    hit = thr_usable & flag_free & thr_reached;
    next_flag = cnt_word[`AST_FLAG_BIT] | hit;
  end

  // control, event capture and counter sequencer
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl          <= `AST_CTRL_RESET;
      srv_port      <= 3'h0;
      srv_chan      <= 5'h00;
      pend          <= 16'h0000;
      cur_port      <= 3'h0;
      cur_chan      <= 5'h00;
      cur_idx       <= 4'h0;
      state         <= ST_IDLE;
      cnt_word      <= 32'h0000_0000;
      queue_count   <= 16'h0000;
      last_entry    <= 16'h0000;
      dropped       <= 16'h0000;
      buf_restart   <= 1'b0;
      starve_insert <= 1'b0;
      ram_req       <= 1'b0;
      ram_we        <= 1'b0;
      ram_addr      <= 18'h00000;
      ram_wdata     <= 32'h0000_0000;
      queue_push    <= 1'b0;
      queue_entry   <= 16'h0000;
    end
    else if (clk_en)
    begin
      queue_push    <= 1'b0;
      buf_restart   <= 1'b0;
      starve_insert <= 1'b0;
      ram_req       <= 1'b0;
      ram_we        <= 1'b0;
      if (apb_wr && paddr == `AST_OFF_CTRL)
        ctrl <= pwdata;
      // buf_restart follows valid ev_uf_start with restart set, starve_insert valid ev_starve with restart clear, even refused ones
      if (ev_valid && ev_uf_start && restart_on)
        buf_restart <= 1'b1;
      if (ev_valid && starve_req)
        starve_insert <= 1'b1;
      // active events with a nonzero counter set refused while not ready are counted in dropped and never tallied
      if (ev_drop)
        dropped <= dropped + 16'h0001;
      if (ev_take)
      begin
        pend     <= ev_vec;
        cur_port <= ev_port;
        cur_chan <= ev_unstructured ? `AST_UNSTR_CHAN : ev_chan;
      end
      case (state)
        ST_IDLE:
        begin
          // start read of lowest pending counter
          if (pick_ok)
          begin
            cur_idx  <= pick;
            ram_req  <= 1'b1;
            ram_addr <= `AST_CNT_BASE | {5'h00, use_port, use_chan, pick, 1'b0};
            srv_port <= use_port;
            srv_chan <= use_chan;
            state    <= ST_RDCNT;
          end
        end
        ST_RDCNT:
        begin
          // fetch the matching threshold word
          ram_req  <= 1'b1;
          ram_addr <= srv_thr_addr;
          state    <= ST_RDTHR;
        end
        ST_RDTHR:
        begin
          // counter word stands on ram_rdata now
          cnt_word <= ram_rdata;
          state    <= ST_WAIT;
        end
        ST_WAIT:
        begin
          // write back while engine is busy: no other update can interleave
          ram_req   <= 1'b1;
          ram_we    <= 1'b1;
          ram_addr  <= srv_cnt_addr;
          ram_wdata <= {next_flag, next_val};
          if (hit)
          begin
            queue_push  <= 1'b1;
            queue_entry <= srv_entry;
            last_entry  <= srv_entry;
            queue_count <= queue_count + 16'h0001;
          end
          pend[cur_idx] <= 1'b0;
          state         <= ST_WRITE;
        end
        ST_WRITE:
        begin
          // write lands in ram this cycle
          state <= ST_IDLE;
        end
        default:
        begin
          // unused codes fall back to idle
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // register read mux
  always @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      prdata <= 32'h0000_0000;
    else if (clk_en && apb_rd)
    begin
      case (paddr)
        `AST_OFF_CTRL:    prdata <= ctrl;
        `AST_OFF_STATUS:  prdata <= {13'h0000, state, pend};
        `AST_OFF_QUEUE:   prdata <= {16'h0000, queue_count};
        `AST_OFF_LAST:    prdata <= {16'h0000, last_entry};
        `AST_OFF_DROPPED: prdata <= {16'h0000, dropped};
        default:          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // ast_counter_engine

// ---- tb/ast_ram_model.sv ----
// statistics ram model behind the counter engine
// assumes word index in ram_addr[13:1], one cycle read latency
module ast_ram_model (
  input  wire logic        core_clk,
  input  wire logic        ram_req,
  input  wire logic        ram_we,
  input  wire logic [17:0] ram_addr,
  input  wire logic [31:0] ram_wdata,
  output logic      [31:0] ram_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:8191];
  initial ram_rdata = '0;
  // data only after a read, otherwise a changing pattern
  always @(posedge core_clk)
  begin
    if (ram_req && ram_we)
      mem[ram_addr[13:1]] <= ram_wdata;
    ram_rdata <= (ram_req && !ram_we) ? mem[ram_addr[13:1]] : ~ram_rdata;
  end
endmodule // ast_ram_model

// ---- tb/ast_counter_engine_assertions.sv ----
// port checker for the statistics counter engine
// assumes one cycle ram read latency; bound into the engine
module ast_engine_chk (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic        ev_valid,
  input wire logic        ev_starve,
  input wire logic        ev_uf_start,
  input wire logic        buf_restart,
  input wire logic        starve_insert,
  input wire logic        ram_req,
  input wire logic        ram_we,
  input wire logic [17:0] ram_addr,
  input wire logic [31:0] ram_wdata,
  input wire logic [31:0] ram_rdata,
  input wire logic        queue_push,
  input wire logic [15:0] queue_entry
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_entry; queue_push |-> queue_entry == {4'h8, ram_addr[12:1]}; endproperty
  a_entry: assert property (p_entry) else $error("bad queue entry");
  property p_once; queue_push |-> ram_we && !$past(ram_rdata[31], 2) && $past(ram_rdata[31]); endproperty
  a_once: assert property (p_once) else $error("bad push");
  property p_reach;
    queue_push |-> $past(ram_rdata[30:0]) <= 31'h4000_0000 && ram_wdata[30:0] >= $past(ram_rdata[30:0]);
  endproperty
  a_reach: assert property (p_reach) else $error("push below threshold");
  property p_sat;
    ram_we && !ram_addr[13] |-> ram_wdata[30:0] == ($past(ram_rdata[30:0], 2) < 31'h4000_0000 ?
      $past(ram_rdata[30:0], 2) + 31'h1 : $past(ram_rdata[30:0], 2));
  endproperty
  a_sat: assert property (p_sat) else $error("bad count");
  property p_flag; ram_we && !ram_addr[13] |-> ram_wdata[31] == ($past(ram_rdata[31], 2) || queue_push); endproperty
  a_flag: assert property (p_flag) else $error("bad flag");
  property p_rmw; ram_we |-> ram_addr[17:13] == 5'h10 && $past(ram_req, 3) && $past(ram_addr, 3) == ram_addr; endproperty
  a_rmw: assert property (p_rmw) else $error("write without read");
  property p_shared; ram_we && ram_addr[4:1] == 4'h0 |-> ram_addr[12:5] == 8'hff; endproperty
  a_shared: assert property (p_shared) else $error("shared tally misplaced");
  property p_starve; starve_insert |-> $past(ev_valid && ev_starve) && !buf_restart; endproperty
  a_starve: assert property (p_starve) else $error("bad starve");
  property p_restart; buf_restart |-> $past(ev_valid && ev_uf_start); endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  c_push: cover property (queue_push);
  c_restart: cover property (buf_restart);
  c_starve: cover property (starve_insert);
endmodule // ast_engine_chk

bind ast_counter_engine ast_engine_chk u_chk (.core_clk, .rst_b, .ev_valid, .ev_starve, .ev_uf_start, .buf_restart,
  .starve_insert, .ram_req, .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .queue_push, .queue_entry);

// ---- tb/test_aal_stats_counter_threshold.sv ----
// self-checking bench for the statistics counter engine
// assumes the ram model as far side and apb access
module test_aal_stats_counter_threshold;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic        ev_valid = 1'b0, ev_active = 1'b1, ev_unstructured = 1'b0, ev_aal1 = 1'b1;
  logic [2:0]  ev_port = '0;
  logic [4:0]  ev_chan = '0;
  logic [6:0]  ev_ptr_value = 7'h64;
  logic [17:0] evf = '0;
  logic [1:0]  pulse;
  logic [15:0] qe;
  wire         pready, pslverr, ev_ready, buf_restart, starve_insert, ram_req, ram_we, queue_push;
  wire  [31:0] prdata, ram_wdata, ram_rdata;
  wire  [17:0] ram_addr;
  wire  [15:0] queue_entry;
  int          checks = 0, miscompares = 0, cyc = 0, qn = 0;
  logic [17:0] sf[5] = '{18'h2, 18'h4, 18'h8, 18'h1_0000, 18'h2_0400};
  logic [3:0]  sk[5] = '{4'h4, 4'h6, 4'h6, 4'h7, 4'ha};
  logic [31:0] se[5] = '{32'h2, 32'h2, 32'h3, 32'h2, 32'h2};
  logic [3:0]  tk[5] = '{4'h6, 4'h6, 4'h4, 4'h5, 4'h8};
  logic [31:0] ti[5] = '{32'h1, 32'h8000_0002, 32'h4000_0000, 32'h3fff_ffff, 32'h0};
  logic [31:0] tt[5] = '{32'h8000_0002, 32'h8000_0002, 32'hffff_ffff, 32'hc000_0000, 32'h1};
  logic [31:0] tc[5] = '{32'h8000_0002, 32'h8000_0003, 32'h4000_0000, 32'hc000_0000, 32'h1};
  int          tq[5] = '{1, 1, 1, 2, 2};
  ast_counter_engine dut (.*, .ev_shared_drop(evf[0]), .ev_ovr_discard(evf[1]), .ev_hdr_crc_fixed(evf[2]),
    .ev_hdr_crc_bad(evf[3]), .ev_ovr_cross(evf[4]), .ev_ovr_end(evf[5]), .ev_hdr_parity(evf[6]),
    .ev_sc_sync_oos(evf[7]), .ev_misinsert(evf[8]), .ev_sc_discard(evf[9]), .ev_ptr_seen(evf[10]),
    .ev_multi_ptr(evf[11]), .ev_uf_start(evf[12]), .ev_starve(evf[13]), .ev_reframe(evf[14]),
    .ev_lost(evf[15]), .ev_sc_inv_oosync(evf[16]), .ev_ptr_parity(evf[17]));
  ast_ram_model ram (.*);
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (queue_push)
      qn++;
    if (queue_push)
      qe = queue_entry;
    if (cyc == 5000)
    begin
      miscompares++;
      results;
    end
  end
  function automatic int ix(int t, int p, int c, int k);
    return t * 4096 + p * 512 + c * 16 + k;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic ev(input logic [2:0] p, input logic [4:0] c, input logic [17:0] f);
    int i;
    ev_valid <= 1'b1;
    ev_port <= p;
    ev_chan <= c;
    evf <= f;
    @(posedge core_clk);
    ev_valid <= 1'b0;
    evf <= '0;
    #1 pulse = {buf_restart, starve_insert};
    i = 0;
    do
    begin
      @(posedge core_clk);
      i++;
    end
    while (ev_ready !== 1'b1 && i < 50);
    if (i >= 50)
      miscompares++;
    @(posedge core_clk);
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    foreach (ram.mem[i])
      ram.mem[i] = '0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 12'h000, '0);
    chk("ctrl reset", 32'h0000_0001, rd);
    apb(1'b0, 12'h014, '0);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 12'h000, 32'hffff_0005);
    apb(1'b0, 12'h000, '0);
    chk("ctrl", 32'hffff_0005, rd);
    for (int k = 4; k < 16; k++)
    begin
      ev(3'h1, 5'h02, 18'h1 << k);
      chk("tally", 32'h1, ram.mem[ix(0, 1, 2, k)]);
      chk("pulse", {31'h0, k == 13}, {30'h0, pulse});
    end
    ev_ptr_value <= 7'h05;
    foreach (sf[j])
    begin
      ev(3'h1, 5'h02, sf[j]);
      chk("variant", se[j], ram.mem[ix(0, 1, 2, sk[j])]);
    end
    ev_ptr_value <= 7'h5d;
    ev(3'h1, 5'h02, 18'h400);
    ev_ptr_value <= 7'h7f;
    ev(3'h1, 5'h02, 18'h400);
    chk("ptr bounds", 32'h2, ram.mem[ix(0, 1, 2, 10)]);
    foreach (tk[j])
    begin
      ram.mem[ix(0, 3, 7, tk[j])] = ti[j];
      ram.mem[ix(1, 3, 7, tk[j])] = tt[j];
      ev(3'h3, 5'h07, 18'h1 << tk[j]);
      chk("count", tc[j], ram.mem[ix(0, 3, 7, tk[j])]);
      chk("pushes", tq[j], qn);
    end
    chk("entry", 32'h8675, {16'h0, qe});
    ev_unstructured <= 1'b1;
    ev(3'h4, 5'h09, 18'h10);
    chk("unstructured", 32'h1, ram.mem[ix(0, 4, 0, 4)]);
    ev_unstructured <= 1'b0;
    ev(3'h2, 5'h05, 18'h1);
    chk("shared", 32'h1, ram.mem[ix(0, 7, 31, 0)]);
    ev_active <= 1'b0;
    ev(3'h5, 5'h01, 18'h40);
    ev_active <= 1'b1;
    apb(1'b1, 12'h000, 32'hffbf_0007);
    ev(3'h5, 5'h01, 18'h40);
    chk("gated", 32'h0, ram.mem[ix(0, 5, 1, 6)]);
    ev(3'h6, 5'h00, 18'h3000);
    chk("restart", 32'h2, {30'h0, pulse});
    chk("no starve", 32'h0, ram.mem[ix(0, 6, 0, 13)]);
    results;
  end
endmodule // test_aal_stats_counter_threshold
